// ---- dv/periodic_wakeup_counter_checker.sv ----
// port assertions for the periodic wakeup counter
`timescale 1ns/1ps
module periodic_wakeup_counter_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic debug_halt,
   input wire logic irq
);
   logic [7:0] mat;
   logic [6:0] ctl;
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   wire a_ctl = paddr == wakeup_pkg::off_status_control;
   wire a_cnt = paddr == wakeup_pkg::off_live_count;
   wire a_mat = paddr == wakeup_pkg::off_match_limit;
   wire hit = a_ctl || a_cnt || a_mat;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow of the writable fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mat <= 8'h00;
         ctl <= 7'h00;
      end else if (acc && pwrite) begin
         if (a_mat) mat <= pwdata[7:0];
         if (a_ctl) ctl <= pwdata[6:0];
      end
   end
   match_read_a: assert property (rd && a_mat |-> prdata == {24'h0, mat}) else $error("match read");
   ctl_read_a: assert property (rd && a_ctl |-> prdata[6:0] == ctl) else $error("control read");
   unmapped_err_a: assert property (acc && !hit |-> pslverr && prdata == 32'h0) else $error("unmapped");
   err_phase_a: assert property (pslverr |-> acc && !hit) else $error("stray error");
   zero_wait_a: assert property (acc |-> pready) else $error("wait state");
   irq_clear_a: assert property ($fell(irq) |-> $past(acc && pwrite && a_ctl)) else $error("irq drop");
   irq_enable_a: assert property (irq |-> ctl[4]) else $error("irq masked");
   halt_hold_a: assert property ((debug_halt && rd && a_cnt) ##3 (debug_halt && rd && a_cnt) |->
      prdata == $past(prdata, 3)) else $error("halt count");
endmodule : periodic_wakeup_counter_checker

// ---- dv/periodic_wakeup_counter_tb.sv ----
// self-checking bench for the periodic wakeup counter
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module periodic_wakeup_counter_tb;
   localparam logic [11:0] actl = wakeup_pkg::off_status_control;
   localparam logic [11:0] acnt = wakeup_pkg::off_live_count;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, debug_halt = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [2:0] pins = 3'h0;
   logic [31:0] prdata, rv;
   logic pready, pslverr, irq, ev;
   int failures = 0, n_compared = 0, cyc = 0;
   int tbl[16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
   always #25 pclk = ~pclk;
   periodic_wakeup_counter periodic_wakeup_counter_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_power_osc_clock(pins[0]), .external_ref_clock(pins[1]),
      .internal_ref_clock(pins[2]), .debug_halt(debug_halt), .irq(irq));
   task automatic print_verdict();
      if (failures == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb
   // pin edges slow enough for the three-flop sampler
   task automatic pulses(input int n, input int s);
      repeat (n) begin
         pins[s] <= 1'h1;
         repeat (4) @(posedge pclk);
         pins[s] <= 1'h0;
         repeat (4) @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
   endtask : pulses
   task automatic run(input logic [1:0] src, input logic [3:0] div);
      int m, n, nd, p, c, f, s;
      logic [31:0] cw;
      s = src[1] ? 2 : int'(src);
      nd = src[0] ? 1000 : tbl[div];
      m = $urandom % 3;
      cw = {25'h0, src, 1'h1, div};
      apb(1'h1, wakeup_pkg::off_match_limit, 32'(m));
      pulses(2, s);
      apb(1'h1, actl, cw | 32'h80);
      n = nd + 1 + $urandom % 3;
      pulses(n, s);
      p = 0;
      c = 0;
      f = 0;
      for (int i = 0; i < n; i++) begin
         if (nd != 0) p++;
         if (nd != 0 && p == nd) begin
            p = 0;
            f = (c == m) ? 1 : f;
            c = (c == m) ? 0 : c + 1;
         end
      end
      apb(1'h0, acnt, 32'h0);
      `CHK("live_count", 32'(c), rv)
      apb(1'h0, actl, 32'h0);
      `CHK("status_control", cw | {24'h0, f[0], 7'h0}, rv)
      apb(1'h1, actl, cw);
      `CHK("irq", f[0], irq)
      apb(1'h1, actl, cw | 32'h80);
      `CHK("irq", 1'h0, irq)
      debug_halt <= 1'h1;
      apb(1'h1, acnt, 32'hff);
      pulses(3, s);
      repeat (2) begin
         apb(1'h0, acnt, 32'h0);
         `CHK("held count", 32'(c), rv)
      end
      debug_halt <= 1'h0;
   endtask : run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 70000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(4022));
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      for (int i = 0; i < 4; i++) begin
         apb(1'h0, 12'(4 * i), 32'h0);
         `CHK("reset value", 32'h0, rv)
      end
      `CHK("unmapped error", 1'h1, ev)
      for (int d = 0; d < 16; d++) run(2'h0, 4'(d));
      run(2'h1, 4'h8);
      run(2'h2, 4'h9);
      run(2'h3, 4'h8);
      print_verdict();
   end
endmodule : periodic_wakeup_counter_tb
bind periodic_wakeup_counter periodic_wakeup_counter_checker periodic_wakeup_counter_checker_inst (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt), .irq(irq));

// ---- src/periodic_wakeup_counter.sv ----
// periodic wakeup counter with prescaler, match compare and apb registers
//
// How it works
// - reset: counter 0x00 stopped, match 0x00, prescaler off, 1 kHz source
// - live count register is read-only; writes change nothing
// - reset, match write, or changed source/divider clears counter
// - any match write also clears the prescaler
// - divider select 0000 keeps prescaler off; non-zero starts it
// - source 00 low-power, 01 external, 1x internal reference
// - changed source select clears prescaler and counter
// - ratio from divider select and source bit 0; change clears both
// - 1 kHz source: 0001 gives 8 ms, 1111 gives 1 s
// - counter steps per prescaler period up to match, then wraps to 0x00
// - flag sets on the step from match value back to 0x00
// - match 0x00 sets flag on every prescaler output edge
// - interrupt request is flag and enable
// - writing 0 to flag does nothing; reset clears it
// - control register: flag 7, source 6:5, enable 4, divider 3:0
// - divide table for source bit 0 clear and set
// - debug halt suspends counting; resumes from held value
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module periodic_wakeup_counter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_power_osc_clock,
   input wire logic external_ref_clock,
   input wire logic internal_ref_clock,
   input wire logic debug_halt,
   output logic irq
);
   localparam int dw = wakeup_pkg::div_width;

   logic [7:0] live_count;
   logic [7:0] match_limit;
   logic periodic_flag;
   logic periodic_irq_enable;
   logic [1:0] source_select;
   logic [3:0] divider_select;
   logic [dw-1:0] prescale;
   logic [2:0] pin_vec;
   logic [2:0] rise_vec;
   logic src_rise;
   logic tick;
   logic wr;
   logic wr_sc;
   logic wr_match;
   logic cfg_change;
   logic clear_all;
   logic [dw-1:0] ratio;

   // divide-by value per divider select and source bit 0
   function automatic logic [dw-1:0] divide_ratio(input logic hi, input logic [3:0] sel);
      logic [dw-1:0] r;
      r = '0;
      if (!hi) begin
         unique case (sel)
            4'h1: r = 18'h00008;
            4'h2: r = 18'h00020;
            4'h3: r = 18'h00040;
            4'h4: r = 18'h00080;
            4'h5: r = 18'h00100;
            4'h6: r = 18'h00200;
            4'h7: r = 18'h00400;
            4'h8: r = 18'h00001;
            4'h9: r = 18'h00002;
            4'ha: r = 18'h00004;
            4'hb: r = 18'h0000a;
            4'hc: r = 18'h00010;
            4'hd: r = 18'h00064;
            4'he: r = 18'h001f4;
            4'hf: r = 18'h003e8;
            default: r = '0;
         endcase
      end else begin
         unique case (sel)
            4'h1: r = 18'h00400;
            4'h2: r = 18'h00800;
            4'h3: r = 18'h01000;
            4'h4: r = 18'h02000;
            4'h5: r = 18'h04000;
            4'h6: r = 18'h08000;
            4'h7: r = 18'h10000;
            4'h8: r = 18'h003e8;
            4'h9: r = 18'h007d0;
            4'ha: r = 18'h01388;
            4'hb: r = 18'h02710;
            4'hc: r = 18'h04e20;
            4'hd: r = 18'h0c350;
            4'he: r = 18'h186a0;
            4'hf: r = 18'h30d40;
            default: r = '0;
         endcase
      end
      return r;
   endfunction : divide_ratio

   assign pin_vec = {internal_ref_clock, external_ref_clock, low_power_osc_clock};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         source_edge_sync u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .pin(pin_vec[g]),
            .rise(rise_vec[g])
         );
      end
   endgenerate

   always_comb begin
      unique case (source_select)
         wakeup_pkg::src_low_power: src_rise = rise_vec[0];
         wakeup_pkg::src_external: src_rise = rise_vec[1];
         default: src_rise = rise_vec[2];
      endcase
   end

   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign wr_sc = wr && paddr == wakeup_pkg::off_status_control;
   assign wr_match = wr && paddr == wakeup_pkg::off_match_limit;
   assign cfg_change = wr_sc && (pwdata[wakeup_pkg::pos_src_hi:wakeup_pkg::pos_src_lo] != source_select
      || pwdata[wakeup_pkg::pos_div_hi:wakeup_pkg::pos_div_lo] != divider_select);
   assign clear_all = wr_match || cfg_change;
   assign ratio = divide_ratio(source_select[0], divider_select);
   assign tick = src_rise && divider_select != 4'h0 && !debug_halt
      && prescale == ratio - 18'h00001;

   // configuration fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_select <= wakeup_pkg::rst_source;
         divider_select <= wakeup_pkg::rst_divider;
         periodic_irq_enable <= 1'b0;
      end else if (wr_sc) begin
         source_select <= pwdata[wakeup_pkg::pos_src_hi:wakeup_pkg::pos_src_lo];
         divider_select <= pwdata[wakeup_pkg::pos_div_hi:wakeup_pkg::pos_div_lo];
         periodic_irq_enable <= pwdata[wakeup_pkg::pos_irq_en];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_limit <= wakeup_pkg::rst_match;
      end else if (wr_match) begin
         match_limit <= pwdata[7:0];
      end
   end

   // prescaler counts source edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= '0;
      end else if (clear_all || divider_select == 4'h0) begin
         prescale <= '0;
      end else if (src_rise && !debug_halt) begin
         if (tick) begin
            prescale <= '0;
         end else begin
            prescale <= prescale + 18'h00001;
         end
      end
   end

   // main counter; live_count is never written by the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         live_count <= wakeup_pkg::rst_count;
      end else if (clear_all) begin
         live_count <= 8'h00;
      end else if (tick) begin
         if (live_count == match_limit) begin
            live_count <= 8'h00;
         end else begin
            live_count <= live_count + 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periodic_flag <= 1'b0;
      end else if (tick && live_count == match_limit && !clear_all) begin
         periodic_flag <= 1'b1;
      end else if (wr_sc && pwdata[wakeup_pkg::pos_flag]) begin
         periodic_flag <= 1'b0;
      end
   end

   assign irq = periodic_flag && periodic_irq_enable;

   always_comb begin
      prdata = 32'h00000000;
      pslverr = 1'b0;
      if (psel && penable) begin
         unique case (paddr)
            wakeup_pkg::off_status_control:
               prdata[7:0] = {periodic_flag, source_select, periodic_irq_enable, divider_select};
            wakeup_pkg::off_live_count: prdata[7:0] = live_count;
            wakeup_pkg::off_match_limit: prdata[7:0] = match_limit;
            default: pslverr = 1'b1;
         endcase
      end
   end
endmodule : periodic_wakeup_counter

// ---- src/source_edge_sync.sv ----
// three-stage synchroniser and rising edge detector for a counting clock pin
`timescale 1ns/1ps
module source_edge_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic rise
);
   logic [wakeup_pkg::sync_stages-1:0] stage;
   logic level;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage <= '0;
      end else begin
         stage <= {stage[wakeup_pkg::sync_stages-2:0], pin};
      end
   end

   // level follows only when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level <= 1'b0;
      end else if (stage[1] == stage[2]) begin
         level <= stage[2];
      end
   end

   assign rise = (stage[1] == stage[2]) && stage[2] && !level;
endmodule : source_edge_sync

// ---- src/wakeup_pkg.sv ----
// constants for the periodic wakeup counter
package wakeup_pkg;
   localparam logic [11:0] off_status_control = 12'h000;
   localparam logic [11:0] off_live_count = 12'h004;
   localparam logic [11:0] off_match_limit = 12'h008;
   localparam int pos_flag = 7;
   localparam int pos_src_hi = 6;
   localparam int pos_src_lo = 5;
   localparam int pos_irq_en = 4;
   localparam int pos_div_hi = 3;
   localparam int pos_div_lo = 0;
   localparam logic [7:0] rst_count = 8'h00;
   localparam logic [7:0] rst_match = 8'h00;
   localparam logic [1:0] rst_source = 2'h0;
   localparam logic [3:0] rst_divider = 4'h0;
   localparam logic [1:0] src_low_power = 2'h0;
   localparam logic [1:0] src_external = 2'h1;
   localparam int div_width = 18;
   localparam int sync_stages = 3;
endpackage : wakeup_pkg
